// ### rtl/tos_cfg.svh
// Offsets, field positions, reset values and timing of the timed output channel.
// Assumes byte addresses on an 8-bit register address, one 32-bit word per register.
`ifndef TOS_CFG_SVH
`define TOS_CFG_SVH
`define TOS_A_DRV 8'h00
`define TOS_A_PERIOD 8'h04
`define TOS_A_MTO 8'h08
`define TOS_A_CFG 8'h0C
`define TOS_A_LVL 8'h10
`define TOS_A_TIME0 8'h14
`define TOS_A_STAT 8'h40
`define TOS_A_PAST 8'h44
`define TOS_B_EN 0
`define TOS_B_TRI 1
`define TOS_B_PWM 2
`define TOS_B_ERRCLR 3
`define TOS_B_DUTY 8
`define TOS_B_BUFCLR 0
`define TOS_B_MANLVL 1
`define TOS_B_FORCE 2
`define TOS_B_MANEN 3
`define TOS_B_ORDER 8
`define TOS_B_NEVT 16
`define TOS_B_PERMIT 0
`define TOS_B_DEFPER 16
`define TOS_B_SHORT 0
`define TOS_B_OVF 1
`define TOS_B_STATE 2
`define TOS_B_WARN 3
`define TOS_B_CYC 4
`define TOS_B_FEEDBACK 8
`define TOS_B_REMAIN 16
`define TOS_RST_WORD 32'h0000_0000
`define TOS_FRAME_EVTS 10
`define TOS_CLK_NS 100
`define TOS_MS_NS 1000000
`define TOS_CYC_PER_MS (`TOS_MS_NS / `TOS_CLK_NS)
`endif

// ### rtl/tos_pkg.sv
// Types shared by the timed output channel and its PWM generator.
// Assumes tos_cfg.svh for all numbers.
package tos_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } tos_bus_s;
  typedef struct packed {
    logic valid;
    logic level;
    logic [31:0] stamp;
  } tos_evt_s;
  typedef struct packed {
    logic on;
    logic tristate;
    logic level;
  } tos_drive_s;
  typedef enum logic [1:0] {
    TOS_LD_IDLE = 2'b01,
    TOS_LD_RUN = 2'b10
  } tos_ld_e;
endpackage : tos_pkg

// ### rtl/tos_pwm.sv
// PWM waveform generator for the driver stage.
// Assumes a period in ms and an 8-bit duty factor, both steady for many cycles.
`timescale 1ns/1ps
`include "tos_cfg.svh"
module tos_pwm #(
  parameter int CYC_PER_MS = `TOS_CYC_PER_MS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [15:0] periodMs,
  input wire logic [7:0] duty,
  output logic wave
);
  import tos_pkg::*;
  typedef struct packed {
    logic [31:0] cnt;
    logic wave;
  } tos_pwm_st_s;
  tos_pwm_st_s st_q, st_d;
  logic [31:0] periodCyc;
  logic [39:0] highCyc;

  always_comb begin
    periodCyc = 32'(periodMs * 32'(CYC_PER_MS));
    highCyc = (40'(periodCyc) * 40'(duty)) >> 8;
    st_d = st_q;
    if (periodCyc == 32'h0000_0000 || st_q.cnt >= periodCyc - 32'h0000_0001) begin
      st_d.cnt = 32'h0000_0000;
    end else begin
      st_d.cnt = st_q.cnt + 32'h0000_0001;
    end
    // Zero period parks the wave low rather than letting it float high
    st_d.wave = (periodCyc != 32'h0000_0000) && (40'(st_q.cnt) < highCyc);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign wave = st_q.wave;
endmodule : tos_pwm

// ### rtl/tos_channel.sv
// One channel of the timestamped output scheduler with its driver-stage control.
// Assumes a synchronised system time, one busCycle pulse per bus cycle and
// a register master that never issues read and write together.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "tos_cfg.svh"
module tos_channel #(
  parameter int DEPTH = 16,
  parameter int WARN_W = 4,
  parameter int CYC_PER_MS = `TOS_CYC_PER_MS
) (
  input wire logic clk,
  input wire logic reset_n,
  input tos_pkg::tos_bus_s bus,
  output logic [31:0] rdData,
  input wire logic busCycle,
  input wire logic [31:0] sysTime,
  input wire logic shortDetect,
  input wire logic [WARN_W-1:0] warnDetect,
  output tos_pkg::tos_drive_s drive
);
  import tos_pkg::*;
  localparam int IW = $clog2(DEPTH);
  localparam int NF = `TOS_FRAME_EVTS;

  typedef struct packed {
    logic [15:0] drvReg;
    logic [15:0] periodReg;
    logic [23:0] mtoReg;
    logic [31:0] cfgReg;
    logic [NF-1:0] lvlReg;
    logic [NF-1:0][31:0] timeReg;
    logic [NF-1:0] stgLvl;
    logic [NF-1:0][31:0] stgTime;
    tos_ld_e ld;
    logic [3:0] ldIdx;
    logic [3:0] ldCnt;
    tos_evt_s [DEPTH-1:0] slot;
    logic [1:0] cyc;
    logic [7:0] orderAck;
    logic [15:0] pastCnt;
    logic shortF;
    logic ovfF;
    logic warnF;
    logic level;
    logic errPrev;
    logic [15:0] periodEff;
    logic [31:0] rdData;
    tos_drive_s drive;
  } tos_st_s;

  tos_st_s st_q, st_d;
  logic [7:0] used;
  logic [8:0] freeCnt;
  logic haveFree;
  logic found;
  logic [IW-1:0] firstFree;
  logic [IW-1:0] best;
  logic [3:0] nEvt;
  logic acceptNow;
  logic errRise;
  logic manualOn;
  logic pwmWave;
  logic [31:0] statusWord;

  // True when stamp a lies before stamp b; wrap-safe over the 32-bit time base
  function automatic logic tos_before(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] diff;
    diff = a - b;
    return diff[31];
  endfunction : tos_before

  tos_pwm #(.CYC_PER_MS(CYC_PER_MS)) u_pwm (
    .clk(clk),
    .reset_n(reset_n),
    .periodMs(st_q.periodEff),
    .duty(st_q.drvReg[`TOS_B_DUTY +: 8]),
    .wave(pwmWave)
  );

  // Slot scan: occupancy, first free slot and earliest pending event
  always_comb begin
    used = 8'h00;
    haveFree = 1'b0;
    found = 1'b0;
    firstFree = '0;
    best = '0;
    for (int i = 0; i < DEPTH; i++) begin
      if (st_q.slot[i].valid) begin
        used = used + 8'h01;
        if (!found || tos_before(st_q.slot[i].stamp, st_q.slot[best].stamp)) begin
          found = 1'b1;
          best = IW'(i);
        end
      end else if (!haveFree) begin
        haveFree = 1'b1;
        firstFree = IW'(i);
      end
    end
    freeCnt = 9'(DEPTH) - {1'b0, used};
  end

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`TOS_B_SHORT] = st_q.shortF;
    statusWord[`TOS_B_OVF] = st_q.ovfF;
    statusWord[`TOS_B_STATE] = st_q.drive.level;
    statusWord[`TOS_B_WARN] = st_q.warnF;
    statusWord[`TOS_B_CYC +: 2] = st_q.cyc;
    statusWord[`TOS_B_FEEDBACK +: 8] = st_q.orderAck;
    statusWord[`TOS_B_REMAIN +: 8] = used;
  end

  always_comb begin
    st_d = st_q;
    st_d.rdData = 32'h0000_0000;
    // Register writes
    if (bus.wr) begin
      case (bus.addr)
        `TOS_A_DRV: st_d.drvReg = bus.wdata[15:0];
        `TOS_A_PERIOD: st_d.periodReg = bus.wdata[15:0];
        `TOS_A_MTO: st_d.mtoReg = bus.wdata[23:0];
        `TOS_A_CFG: st_d.cfgReg = bus.wdata;
        `TOS_A_LVL: st_d.lvlReg = bus.wdata[NF-1:0];
        default: st_d.cfgReg = st_q.cfgReg;
      endcase
      for (int i = 0; i < NF; i++) begin
        if (bus.addr == 8'(`TOS_A_TIME0 + 4 * i)) begin
          st_d.timeReg[i] = bus.wdata;
        end
      end
    end
    // Register reads; unmapped addresses answer zero
    if (bus.rd) begin
      case (bus.addr)
        `TOS_A_DRV: st_d.rdData = {16'h0000, st_q.drvReg};
        `TOS_A_PERIOD: st_d.rdData = {16'h0000, st_q.periodReg};
        `TOS_A_MTO: st_d.rdData = {8'h00, st_q.mtoReg};
        `TOS_A_CFG: st_d.rdData = st_q.cfgReg;
        `TOS_A_LVL: st_d.rdData = 32'(st_q.lvlReg);
        `TOS_A_STAT: st_d.rdData = statusWord;
        `TOS_A_PAST: st_d.rdData = {16'h0000, st_q.pastCnt};
        default: st_d.rdData = 32'h0000_0000;
      endcase
      for (int i = 0; i < NF; i++) begin
        if (bus.addr == 8'(`TOS_A_TIME0 + 4 * i)) begin
          st_d.rdData = st_q.timeReg[i];
        end
      end
    end

    // Short and overflow latch, warning follows its inputs; a new fault in the clearing cycle still wins
    errRise = st_q.drvReg[`TOS_B_ERRCLR] & ~st_q.errPrev;
    st_d.errPrev = st_q.drvReg[`TOS_B_ERRCLR];
    st_d.shortF = (st_q.shortF & ~errRise) | shortDetect;
    st_d.ovfF = st_q.ovfF & ~errRise;
    st_d.warnF = |warnDetect;

    // Frame acceptance
    // A newer frame drops whatever is left of a partial load
    nEvt = (st_q.mtoReg[`TOS_B_NEVT +: 8] > 8'(NF)) ? 4'(NF)
         : st_q.mtoReg[`TOS_B_NEVT +: 4];
    acceptNow = busCycle && (st_q.mtoReg[`TOS_B_ORDER +: 8] != st_q.orderAck)
              && !st_q.mtoReg[`TOS_B_BUFCLR];
    if (busCycle) begin
      st_d.cyc = st_q.cyc + 2'b01;
    end
    if (acceptNow) begin
      st_d.orderAck = st_q.mtoReg[`TOS_B_ORDER +: 8];
      st_d.stgLvl = st_q.lvlReg;
      st_d.stgTime = st_q.timeReg;
      st_d.ldIdx = 4'h0;
      st_d.ldCnt = nEvt;
      if ({5'b0_0000, nEvt} > freeCnt) begin
        st_d.ovfF = 1'b1;
        st_d.ldCnt = freeCnt[3:0];
      end
      st_d.ld = TOS_LD_RUN;
    end

    // Execute the earliest event once its time is reached
    if (found && !tos_before(sysTime, st_q.slot[best].stamp)) begin
      st_d.level = st_q.slot[best].level;
      st_d.slot[best].valid = 1'b0;
    end

    // Loader moves one staged event per clock into a free slot
    // One entry per clock keeps the slot scan a single pass
    case (st_q.ld)
      TOS_LD_IDLE: st_d.ldIdx = st_d.ldIdx;
      TOS_LD_RUN: begin
        if (!acceptNow) begin
          if (st_q.ldIdx >= st_q.ldCnt) begin
            st_d.ld = TOS_LD_IDLE;
          end else begin
            st_d.ldIdx = st_q.ldIdx + 4'h1;
            if (tos_before(st_q.stgTime[st_q.ldIdx], sysTime)
                && !st_q.mtoReg[`TOS_B_FORCE]) begin
              st_d.pastCnt = st_q.pastCnt + 16'h0001;
            end else if (haveFree) begin
              st_d.slot[firstFree].valid = 1'b1;
              st_d.slot[firstFree].level = st_q.stgLvl[st_q.ldIdx];
              st_d.slot[firstFree].stamp = st_q.stgTime[st_q.ldIdx];
            end
          end
        end
      end
      default: st_d.ld = TOS_LD_IDLE;
    endcase

    // Buffer clear outranks loading; an event due in the same cycle still sets the level
    if (st_q.mtoReg[`TOS_B_BUFCLR]) begin
      for (int i = 0; i < DEPTH; i++) begin
        st_d.slot[i].valid = 1'b0;
      end
      st_d.ld = TOS_LD_IDLE;
    end

    // Driver stage
    st_d.periodEff = (st_q.periodReg != 16'h0000) ? st_q.periodReg
                   : st_q.cfgReg[`TOS_B_DEFPER +: 16];
    manualOn = st_q.mtoReg[`TOS_B_MANEN] & st_q.cfgReg[`TOS_B_PERMIT];
    st_d.drive.on = st_q.drvReg[`TOS_B_EN];
    st_d.drive.tristate = st_q.drvReg[`TOS_B_TRI];
    st_d.drive.level = (manualOn ? st_q.mtoReg[`TOS_B_MANLVL] : st_q.level)
                     & (st_q.drvReg[`TOS_B_PWM] ? pwmWave : 1'b1);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= '0;
      st_q.ld <= TOS_LD_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdData = st_q.rdData;
  assign drive = st_q.drive;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_clrRise;
    $rose(st_q.drvReg[`TOS_B_ERRCLR]) && !shortDetect && !acceptNow;
  endsequence
  sequence s_clrDone;
    !st_q.shortF && !st_q.ovfF;
  endsequence
  sequence s_statRead;
    bus.rd && bus.addr == `TOS_A_STAT;
  endsequence

  a_short_flag: assert property (shortDetect |=> st_q.shortF)
    else $error("short not flagged");
  a_overflow_set: assert property (acceptNow && {5'b0_0000, nEvt} > freeCnt |=> st_q.ovfF)
    else $error("overflow not flagged");
  a_state_read: assert property (s_statRead |=> rdData[`TOS_B_STATE] == $past(drive.level))
    else $error("output state misreported");
  a_warn_summary: assert property (|warnDetect |=> st_q.warnF)
    else $error("warning not raised");
  a_cycle_count: assert property (busCycle |=> st_q.cyc == $past(st_q.cyc) + 2'b01)
    else $error("cycle counter wrong");
  a_order_echo: assert property (acceptNow
    |=> st_q.orderAck == $past(st_q.mtoReg[`TOS_B_ORDER +: 8]))
    else $error("order feedback wrong");
  a_no_accept: assert property (busCycle && st_q.mtoReg[15:8] == st_q.orderAck
    |=> st_q.orderAck == $past(st_q.orderAck))
    else $error("events taken without increment");
  a_stage_on: assert property (##1 drive.on == $past(st_q.drvReg[`TOS_B_EN]))
    else $error("driver enable wrong");
  a_stage_tri: assert property (st_q.drvReg[`TOS_B_TRI] [*2] |-> drive.tristate)
    else $error("tristate not applied");
  a_err_clear: assert property (s_clrRise ##1 !shortDetect |-> s_clrDone)
    else $error("errors not cleared");
  a_buf_clear: assert property (st_q.mtoReg[`TOS_B_BUFCLR] |=> used == 8'h00)
    else $error("buffer not cleared");
  a_manual_drive: assert property (manualOn && !st_q.drvReg[`TOS_B_PWM]
    |=> drive.level == $past(st_q.mtoReg[`TOS_B_MANLVL]))
    else $error("manual level not driven");

  // Driver gating, period choice, register stores and loader limits; latched flags and counters move only on their own events
  sequence s_pwmLow;
    !manualOn && st_q.drvReg[`TOS_B_PWM] && !pwmWave;
  endsequence
  a_pwm_gate: assert property (s_pwmLow |=> !drive.level)
    else $error("gated output not low");
  a_period_default: assert property (st_q.periodReg == 16'h0000
    |=> st_q.periodEff == $past(st_q.cfgReg[`TOS_B_DEFPER +: 16]))
    else $error("default period not used");
  a_period_own: assert property (st_q.periodReg != 16'h0000
    |=> st_q.periodEff == $past(st_q.periodReg))
    else $error("own period not used");
  // Past events are inserted under force, so the reject count must hold
  a_force_keep: assert property (st_q.mtoReg[`TOS_B_FORCE]
    |=> st_q.pastCnt == $past(st_q.pastCnt))
    else $error("forced event counted as rejected");
  a_past_step: assert property ($changed(st_q.pastCnt)
    |-> st_q.pastCnt == $past(st_q.pastCnt) + 16'h0001)
    else $error("reject count jumped");
  a_tri_off: assert property (!st_q.drvReg[`TOS_B_TRI] |=> !drive.tristate)
    else $error("tristate without request");
  a_manual_block: assert property (st_q.mtoReg[`TOS_B_MANEN]
    && !st_q.cfgReg[`TOS_B_PERMIT] && !st_q.drvReg[`TOS_B_PWM]
    |=> drive.level == $past(st_q.level))
    else $error("manual mode used without permission");
  a_lvl_write: assert property (bus.wr && bus.addr == `TOS_A_LVL
    |=> st_q.lvlReg == $past(bus.wdata[NF-1:0]))
    else $error("event levels not stored");
  a_time_write: assert property (bus.wr && bus.addr == `TOS_A_TIME0
    |=> st_q.timeReg[0] == $past(bus.wdata))
    else $error("event time not stored");
  a_ld_stop: assert property (st_q.mtoReg[`TOS_B_BUFCLR] |=> st_q.ld == TOS_LD_IDLE)
    else $error("loader runs during buffer clear");
  a_load_limit: assert property (acceptNow && st_q.mtoReg[`TOS_B_NEVT +: 8] <= 8'(NF)
    |=> st_q.ldCnt <= $past(st_q.mtoReg[`TOS_B_NEVT +: 4]))
    else $error("more events loaded than stated");
  a_order_hold: assert property (!busCycle |=> $stable(st_q.orderAck))
    else $error("feedback moved outside a bus cycle");
  a_cycle_hold: assert property (!busCycle |=> $stable(st_q.cyc))
    else $error("cycle counter moved outside a bus cycle");
  a_short_keep: assert property (st_q.shortF && !$rose(st_q.drvReg[`TOS_B_ERRCLR])
    |=> st_q.shortF)
    else $error("short flag lost");
  a_ovf_keep: assert property (st_q.ovfF && !$rose(st_q.drvReg[`TOS_B_ERRCLR])
    |=> st_q.ovfF)
    else $error("overflow flag lost");
  a_remain_read: assert property (s_statRead
    |=> rdData[`TOS_B_REMAIN +: 8] == $past(used))
    else $error("remaining count misreported");
endmodule : tos_channel

// ### testbench/tos_master.sv
// Fieldbus master model: register writes, reads, frames and bus-cycle pulses.
// Assumes a slave that answers reads one cycle later and never waits.
`timescale 1ns/1ps
`include "tos_cfg.svh"
module tos_master (
  input wire logic clk,
  input wire logic [31:0] rdData,
  output tos_pkg::tos_bus_s bus,
  output logic busCycle
);
  import tos_pkg::*;
  int nCyc = 0;
  initial begin
    bus = '0;
    busCycle = 1'b0;
  end
  // Released lines show the inverse, so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: ~bus.wdata, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '{addr: ~a, wdata: bus.wdata, wr: 1'b0, rd: 1'b0};
    #1 d = rdData;
  endtask : rd
  task automatic pulse();
    @(posedge clk);
    busCycle <= 1'b1;
    @(posedge clk);
    busCycle <= 1'b0;
    nCyc++;
  endtask : pulse
  // Clear request is always a fresh zero-to-one step
  task automatic errClr(input logic [31:0] d);
    wr(`TOS_A_DRV, d | 32'h0000_0008);
    wr(`TOS_A_DRV, d);
  endtask : errClr
  // All ten slots written; only cnt of them are meant to count
  task automatic frame(input logic [7:0] ord, input logic [7:0] cnt, input logic [3:0] fl,
                       input logic [9:0] lv, input logic [31:0] base, input int step);
    wr(`TOS_A_LVL, {22'h0, lv});
    for (int i = 0; i < `TOS_FRAME_EVTS; i++) begin
      wr(`TOS_A_TIME0 + 8'(4 * i), base + 32'(i * step));
    end
    wr(`TOS_A_MTO, {8'h00, cnt, ord, 4'h0, fl});
    pulse();
    repeat (`TOS_FRAME_EVTS + 3) @(posedge clk);
    #1;
  endtask : frame
endmodule : tos_master

// ### testbench/timestamped_output_scheduler_tb.sv
// Self-checking bench of one timed output channel.
// Assumes the master model drives the register port and bus-cycle pulses.
`timescale 1ns/1ps
`include "tos_cfg.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module timestamped_output_scheduler_tb;
  import tos_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] sysTime = 32'h0000_1000;
  logic shortDetect = 1'b0;
  logic [3:0] warnDetect = 4'h0;
  tos_bus_s bus;
  logic busCycle;
  logic [31:0] rdData;
  tos_drive_s drive;
  logic [31:0] s;
  logic [31:0] t0;
  int h;
  int err_count = 0;
  int checked = 0;
  always #50 clk = ~clk;
  always @(posedge clk) sysTime <= sysTime + 32'h1;
  // Small depth so one frame overflows it
  tos_channel #(.DEPTH(4), .WARN_W(4), .CYC_PER_MS(10)) DUT (.clk(clk), .reset_n(reset_n),
    .bus(bus), .rdData(rdData), .busCycle(busCycle), .sysTime(sysTime),
    .shortDetect(shortDetect), .warnDetect(warnDetect), .drive(drive));
  tos_master mst (.clk(clk), .rdData(rdData), .bus(bus), .busCycle(busCycle));
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic waitFor(input logic [31:0] t);
    int n;
    n = 0;
    while (sysTime < t + 32'd3 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 1000) begin
      err_count++;
      end_of_test();
    end
    #1;
  endtask : waitFor
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task automatic highs();
    h = 0;
    repeat (40) begin
      @(posedge clk);
      #1;
      if (drive.level === 1'b1) h++;
    end
  endtask : highs
  task automatic t_reset();
    mst.rd(`TOS_A_STAT, s);
    `CHK("status", 32'h0, s)
    mst.rd(`TOS_A_PAST, s);
    `CHK("past", 32'h0, s)
    mst.wr(8'hFC, 32'hFFFF_FFFF);
    mst.rd(8'hFC, s);
    `CHK("unmapped", 32'h0, s)
    `CHK("drive", 3'h0, drive)
    repeat (5) mst.pulse();
    mst.rd(`TOS_A_STAT, s);
    `CHK("cycles", 2'(mst.nCyc), s[5:4])
  endtask : t_reset
  task automatic t_events();
    t0 = sysTime;
    mst.frame(8'h01, 8'd2, 4'h0, 10'b10, t0 + 32'd150, -50);
    mst.rd(`TOS_A_STAT, s);
    `CHK("feedback", 8'h01, s[15:8])
    `CHK("remaining", 8'd2, s[23:16])
    mst.rd(`TOS_A_LVL, s);
    `CHK("levels", 32'h0000_0002, s)
    mst.rd(`TOS_A_TIME0 + 8'h04, s);
    `CHK("time 2", t0 + 32'd100, s)
    waitFor(t0 + 32'd100);
    `CHK("early slot", 1'b1, drive.level)
    mst.rd(`TOS_A_STAT, s);
    `CHK("state", 1'b1, s[2])
    `CHK("remaining", 8'd1, s[23:16])
    waitFor(t0 + 32'd150);
    `CHK("late slot", 1'b0, drive.level)
  endtask : t_events
  task automatic t_order();
    mst.frame(8'h01, 8'd1, 4'h0, 10'h3FF, sysTime + 32'd500, 0);
    mst.rd(`TOS_A_STAT, s);
    `CHK("same order", 8'd0, s[23:16])
    mst.frame(8'h02, 8'd1, 4'h0, 10'h3FF, sysTime + 32'd500, 0);
    mst.rd(`TOS_A_STAT, s);
    `CHK("count field", 8'd1, s[23:16])
    mst.wr(`TOS_A_MTO, {8'h00, 8'd1, 8'h02, 8'h01});
    mst.rd(`TOS_A_STAT, s);
    `CHK("buffer clear", 8'd0, s[23:16])
    mst.frame(8'h03, 8'd10, 4'h0, 10'h000, sysTime + 32'd5000, 1);
    mst.rd(`TOS_A_STAT, s);
    `CHK("full", 8'd4, s[23:16])
    `CHK("overflow", 1'b1, s[1])
    @(posedge clk) shortDetect <= 1'b1;
    @(posedge clk) shortDetect <= 1'b0;
    mst.rd(`TOS_A_STAT, s);
    `CHK("short", 1'b1, s[0])
    mst.errClr(32'h0);
    mst.rd(`TOS_A_STAT, s);
    `CHK("cleared", 2'b00, s[1:0])
    mst.wr(`TOS_A_MTO, {8'h00, 8'd10, 8'h03, 8'h01});
    mst.wr(`TOS_A_MTO, {8'h00, 8'd10, 8'h03, 8'h00});
  endtask : t_order
  task automatic t_past();
    mst.frame(8'h04, 8'd1, 4'h0, 10'h001, sysTime - 32'd10, 0);
    mst.rd(`TOS_A_PAST, s);
    `CHK("past count", 32'd1, s)
    `CHK("skipped", 1'b0, drive.level)
    mst.frame(8'h05, 8'd1, 4'h4, 10'h001, sysTime - 32'd10, 0);
    `CHK("forced", 1'b1, drive.level)
  endtask : t_past
  task automatic t_manual();
    mst.wr(`TOS_A_CFG, 32'h0);
    mst.wr(`TOS_A_MTO, {16'h0, 8'h05, 8'h08});
    settle();
    `CHK("not permitted", 1'b1, drive.level)
    mst.wr(`TOS_A_CFG, 32'h1);
    settle();
    `CHK("manual low", 1'b0, drive.level)
    mst.wr(`TOS_A_MTO, {16'h0, 8'h05, 8'h00});
    settle();
    `CHK("manual off", 1'b1, drive.level)
  endtask : t_manual
  task automatic t_drive();
    mst.wr(`TOS_A_DRV, 32'h3);
    settle();
    `CHK("stage on", 1'b1, drive.on)
    `CHK("tristate", 1'b1, drive.tristate)
    @(posedge clk) warnDetect <= 4'h2;
    mst.rd(`TOS_A_STAT, s);
    `CHK("warning", 1'b1, s[3])
    @(posedge clk) warnDetect <= 4'h0;
    mst.wr(`TOS_A_PERIOD, 32'h0);
    mst.wr(`TOS_A_DRV, 32'h0000_8004);
    highs();
    `CHK("no period", 0, h)
    mst.wr(`TOS_A_CFG, 32'h0001_0001);
    highs();
    `CHK("default period", 1'b1, 1'(h > 0 && h < 40))
    mst.wr(`TOS_A_CFG, 32'h1);
    mst.wr(`TOS_A_PERIOD, 32'h1);
    highs();
    `CHK("own period", 1'b1, 1'(h > 0 && h < 40))
    mst.rd(`TOS_A_PERIOD, s);
    `CHK("period reg", 32'h0000_0001, s)
    mst.rd(`TOS_A_DRV, s);
    `CHK("drive reg", 32'h0000_8004, s)
  endtask : t_drive
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_events();
    t_order();
    t_past();
    t_manual();
    t_drive();
    end_of_test();
  end
endmodule : timestamped_output_scheduler_tb
